// ### sim/cell_array_model.sv
// Behavioural model of the flash cell array behind the control block.
`timescale 1ns/1ps
module cell_array_model (
	// Clock.
	input  wire logic        clk,
	// Cell address and high-voltage drive.
	input  wire logic [14:0] addr,
	input  wire logic        hv_prog,
	input  wire logic        hv_erase,
	input  wire logic        erase_boot,
	input  wire logic [14:0] pgm_addr,
	input  wire logic [15:0] pgm_data,
	// Cell data.
	output logic      [15:0] rdata
);
	logic [15:0] mem_q [0:32767]; // Cells start out erased.
	// Programming only clears bits; erase sets every unguarded cell.
	initial begin
		for (int i = 0; i < 32768; i++)
			mem_q[i] = 16'hFFFF;
	end
	// High voltage acts on the cells while it stands.
	always @(posedge clk) begin
		if (hv_erase) begin
			for (int i = 0; i < 32768; i++)
				if (erase_boot || 15'(i) < flash_pe_pkg::BOOT_BASE)
					mem_q[i] <= 16'hFFFF;
		end else if (hv_prog) begin
			mem_q[pgm_addr] <= mem_q[pgm_addr] & pgm_data;
		end
	end
	assign rdata = mem_q[addr]; // Cell data follows the address.
endmodule

// ### sim/testbench.sv
// Self-checking testbench for the flash program/erase control block.
`timescale 1ns/1ps
module testbench;
	logic        CORE_CLK, RST_B, CTL_WR, TST_WR, ARR_WR, ARR_RD;
	logic        SUPPLY_PRESENT, SPECIAL_MODE, LOW_POWER, rd_v;
	logic        LATCH_FULL, FLASH_READY, RD_VALID;
	logic        HV_PROGRAM, HV_ERASE, ERASE_BOOT;
	logic [4:0]  CTL_WDATA, CTL_RDATA;
	logic [7:0]  TST_WDATA, TST_RDATA;
	logic [14:0] ARR_ADDR, CELL_ADDR, PGM_ADDR;
	logic [15:0] ARR_WDATA, CELL_RDATA, RD_DATA, PGM_DATA, rd_d;
	int          n_mismatch, compares;
	flash_program_erase_control dut_u (.CORE_CLK, .RST_B, .CTL_WR,
		.CTL_WDATA, .TST_WR, .TST_WDATA, .ARR_WR, .ARR_RD, .ARR_ADDR,
		.ARR_WDATA, .CELL_RDATA, .SUPPLY_PRESENT, .SPECIAL_MODE,
		.LOW_POWER, .CTL_RDATA, .TST_RDATA, .LATCH_FULL, .FLASH_READY,
		.RD_VALID, .RD_DATA, .CELL_ADDR, .HV_PROGRAM, .HV_ERASE,
		.ERASE_BOOT, .PGM_ADDR, .PGM_DATA);
	cell_array_model cells_u (.clk(CORE_CLK), .addr(CELL_ADDR),
		.hv_prog(HV_PROGRAM), .hv_erase(HV_ERASE),
		.erase_boot(ERASE_BOOT), .pgm_addr(PGM_ADDR),
		.pgm_data(PGM_DATA), .rdata(CELL_RDATA));
	// The clock runs at 50 MHz.
	initial begin
		CORE_CLK = 1'h0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	// Every bus task ends just after an edge, so its effects have landed.
	task automatic cyc(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask
	// Control register write, one cycle strobe.
	task automatic ctl(input logic [4:0] v);
		@(posedge CORE_CLK);
		CTL_WR    <= 1'h1;
		CTL_WDATA <= v;
		cyc(1);
		CTL_WR <= 1'h0;
	endtask
	// Test register write.
	task automatic tst(input logic [7:0] v);
		@(posedge CORE_CLK);
		TST_WR    <= 1'h1;
		TST_WDATA <= v;
		cyc(1);
		TST_WR <= 1'h0;
	endtask
	// Array write of one word.
	task automatic arr_wr(input logic [14:0] a, input logic [15:0] d);
		@(posedge CORE_CLK);
		ARR_WR    <= 1'h1;
		ARR_ADDR  <= a;
		ARR_WDATA <= d;
		cyc(1);
		ARR_WR <= 1'h0;
	endtask
	// Address leads the read by two edges: the cell address is registered.
	task automatic arr_rd(input logic [14:0] a);
		@(posedge CORE_CLK);
		ARR_ADDR <= a;
		@(posedge CORE_CLK);
		@(posedge CORE_CLK);
		ARR_RD <= 1'h1;
		cyc(1);
		ARR_RD <= 1'h0;
		rd_v = RD_VALID;
		rd_d = RD_DATA;
	endtask
	// Four-state compare of any result up to one word wide.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic results;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog cuts a hang short.
	initial begin
		repeat (5000) @(posedge CORE_CLK);
		n_mismatch++;
		results();
	end
	// Main sequence.
	initial begin
		{RST_B, CTL_WR, TST_WR, ARR_WR, ARR_RD, LOW_POWER} = 6'h00;
		{CTL_WDATA, TST_WDATA, ARR_ADDR, ARR_WDATA} = 44'h0;
		{SUPPLY_PRESENT, SPECIAL_MODE} = 2'h2;
		n_mismatch = 0;
		compares   = 0;
		repeat (2) @(posedge CORE_CLK);
		RST_B <= 1'h1;
		cyc(3);
		chk({HV_PROGRAM, HV_ERASE, LATCH_FULL, CTL_RDATA}, 16'h0);
		ctl(5'h01);
		chk(CTL_RDATA, 5'h00);
		arr_wr(15'h0100, 16'h1234);
		chk(LATCH_FULL, 1'h0);
		ctl(5'h03);
		chk(CTL_RDATA, 5'h02);
		ctl(5'h03);
		chk(CTL_RDATA, 5'h02);
		arr_wr(15'h0100, 16'h1234);
		chk(LATCH_FULL, 1'h1);
		chk(PGM_ADDR, 15'h0100);
		arr_wr(15'h0200, 16'h0000);
		chk(PGM_DATA, 16'h1234);
		arr_rd(15'h0200);
		chk(CELL_ADDR, 15'h0100);
		ctl(5'h03);
		cyc(2);
		chk({HV_ERASE, HV_PROGRAM}, 2'h1);
		ctl(5'h05);
		chk(CTL_RDATA, 5'h03);
		arr_rd(15'h0100);
		chk(rd_v, 1'h0);
		ctl(5'h02);
		cyc(2);
		chk(HV_PROGRAM, 1'h0);
		arr_rd(15'h0300);
		chk(rd_v, 1'h1);
		chk(rd_d, 16'h1234);
		ctl(5'h03);
		ctl(5'h02);
		ctl(5'h00);
		arr_rd(15'h0100);
		chk(rd_d, 16'h1234);
		$display("test program ends");
		ctl(5'h06);
		arr_wr(15'h7FFF, 16'h0000);
		ctl(5'h07);
		cyc(2);
		chk({HV_ERASE, HV_PROGRAM, ERASE_BOOT}, 3'h5);
		ctl(5'h06);
		ctl(5'h00);
		arr_rd(15'h0100);
		chk(rd_d, 16'hFFFF);
		ctl(5'h0A);
		arr_wr(15'h7800, 16'h0000);
		ctl(5'h0B);
		cyc(2);
		chk(HV_PROGRAM, 1'h0);
		ctl(5'h0A);
		ctl(5'h0E);
		arr_wr(15'h0000, 16'h0000);
		ctl(5'h0F);
		cyc(2);
		chk({HV_ERASE, ERASE_BOOT}, 2'h2);
		ctl(5'h0E);
		ctl(5'h00);
		$display("test erase ends");
		@(posedge CORE_CLK) SUPPLY_PRESENT <= 1'h0;
		ctl(5'h02);
		arr_wr(15'h0100, 16'h0000);
		ctl(5'h03);
		cyc(3);
		chk(HV_PROGRAM, 1'h0);
		ctl(5'h02);
		ctl(5'h00);
		@(posedge CORE_CLK) SUPPLY_PRESENT <= 1'h1;
		ctl(5'h02);
		arr_wr(15'h0100, 16'h0000);
		ctl(5'h03);
		cyc(2);
		chk(HV_PROGRAM, 1'h1);
		@(posedge CORE_CLK) LOW_POWER <= 1'h1;
		cyc(5);
		chk({HV_PROGRAM, CTL_RDATA}, 6'h02);
		@(posedge CORE_CLK) LOW_POWER <= 1'h0;
		cyc(14);
		chk(FLASH_READY, 1'h0);
		cyc(1);
		chk(FLASH_READY, 1'h1);
		ctl(5'h10);
		chk(CTL_RDATA, 5'h10);
		$display("test supply ends");
		tst(8'hA5);
		chk(TST_RDATA, 8'h00);
		@(posedge CORE_CLK) SPECIAL_MODE <= 1'h1;
		cyc(3);
		ctl(5'h01);
		chk(CTL_RDATA, 5'h00);
		tst(8'hA5);
		chk(TST_RDATA, 8'hA5);
		@(posedge CORE_CLK) SPECIAL_MODE <= 1'h0;
		cyc(3);
		chk(TST_RDATA, 8'h00);
		$display("test special mode ends");
		results();
	end
endmodule

// ### verilog/flash_pe_pkg.sv
// Package of constants for the flash program/erase control block.
package flash_pe_pkg;
	// Control register field positions.
	localparam int HV_BIT    = 0;
	localparam int LATCH_BIT = 1;
	localparam int ERASE_BIT = 2;
	localparam int BOOT_BIT  = 3;
	localparam int WAKE_BIT  = 4;
	localparam int CTL_W     = 5;
	// Reset value of the control register: everything clear.
	localparam logic [4:0] CTL_RST = 5'h00;
	// Test register width and reset value.
	localparam int TST_W = 8;
	localparam logic [7:0] TST_RST = 8'h00;
	// Array geometry defaults.
	localparam int ADDR_W = 15;
	localparam int DATA_W = 16;
	// Boot block: addresses at or above this base are protected.
	localparam logic [14:0] BOOT_BASE = 15'h7800;
	// Stop recovery time and its cycle count at 50 MHz, rounded up.
	localparam int STOP_REC_NS = 250;
	localparam int CLK_NS      = 20;
	localparam int STOP_REC_CYC = (STOP_REC_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### verilog/flash_program_erase_control.sv
// Program/erase interlock and latch control for an on-chip flash array.
`timescale 1ns/1ps
module flash_program_erase_control #(
	parameter int AW = flash_pe_pkg::ADDR_W,
	parameter int DW = flash_pe_pkg::DATA_W
) (
	// Clock and reset.
	input  wire logic          CORE_CLK,
	input  wire logic          RST_B,
	// Control register write port.
	input  wire logic          CTL_WR,
	input  wire logic [4:0]    CTL_WDATA,
	// Test register write port.
	input  wire logic          TST_WR,
	input  wire logic [7:0]    TST_WDATA,
	// Array access from the processor.
	input  wire logic          ARR_WR,
	input  wire logic          ARR_RD,
	input  wire logic [AW-1:0] ARR_ADDR,
	input  wire logic [DW-1:0] ARR_WDATA,
	// Data read from the array cells.
	input  wire logic [DW-1:0] CELL_RDATA,
	// Asynchronous levels from outside.
	input  wire logic          SUPPLY_PRESENT,
	input  wire logic          SPECIAL_MODE,
	input  wire logic          LOW_POWER,
	// Register and state views.
	output logic [4:0]         CTL_RDATA,
	output logic [7:0]         TST_RDATA,
	output logic               LATCH_FULL,
	output logic               FLASH_READY,
	// Array read answer.
	output logic               RD_VALID,
	output logic [DW-1:0]      RD_DATA,
	output logic [AW-1:0]      CELL_ADDR,
	// High-voltage drive to the array.
	output logic               HV_PROGRAM,
	output logic               HV_ERASE,
	output logic               ERASE_BOOT,
	output logic [AW-1:0]      PGM_ADDR,
	output logic [DW-1:0]      PGM_DATA
);

	// Complete state of the block in one record.
	typedef struct packed {
		logic [1:0]    sup_s;      // Supply synchroniser.
		logic [1:0]    smd_s;      // Special mode synchroniser.
		logic [1:0]    lpw_s;      // Stop/wait synchroniser.
		logic [4:0]    ctl;        // Control register.
		logic [7:0]    tst;        // Test register.
		logic          loaded;     // Latches written since latch set.
		logic          boot_hit;   // Latched address is in boot block.
		logic [AW-1:0] laddr;      // Latched address.
		logic [DW-1:0] ldata;      // Latched data.
		logic [3:0]    rec_cnt;    // Stop recovery counter.
		logic          rdv;        // Read answer valid.
		logic [DW-1:0] rdd;        // Read answer data.
		logic          hvp;        // Program voltage drive.
		logic          hve;        // Erase voltage drive.
		logic          ebt;        // Boot block erase permitted.
	} state_t;

	state_t st_q;  // Registered state.
	state_t st_d;  // Next state.

	// Reset value of the whole record.
	localparam state_t ST_RST = '{
		sup_s: 2'h0, smd_s: 2'h0, lpw_s: 2'h0,
		ctl: flash_pe_pkg::CTL_RST, tst: flash_pe_pkg::TST_RST,
		loaded: 1'b0, boot_hit: 1'b0, laddr: '0, ldata: '0,
		rec_cnt: 4'h0, rdv: 1'b0, rdd: '0,
		hvp: 1'b0, hve: 1'b0, ebt: 1'b0};

	// Tells whether an address falls inside the boot block.
	function automatic logic in_boot(input logic [AW-1:0] a);
		in_boot = (a >= AW'(flash_pe_pkg::BOOT_BASE));
	endfunction

	// Synchronised copies of the outside levels.
	logic sup_ok;  // Supply present.
	logic smd;     // Special mode.
	logic lpw;     // Stop or wait.
	assign sup_ok = st_q.sup_s[1];
	assign smd    = st_q.smd_s[1];
	assign lpw    = st_q.lpw_s[1];

	// Next-state logic for control, latches, reads and drives.
	always_comb begin
		logic hv_now;
		logic want_hv;
		hv_now  = st_q.ctl[flash_pe_pkg::HV_BIT];
		want_hv = 1'b0;
		st_d = st_q;
		// Only the second stage is read elsewhere.
		st_d.sup_s = {st_q.sup_s[0], SUPPLY_PRESENT};
		st_d.smd_s = {st_q.smd_s[0], SPECIAL_MODE};
		st_d.lpw_s = {st_q.lpw_s[0], LOW_POWER};
		st_d.rdv = 1'b0;
		// Control write: under high voltage only the enable may change.
		if (CTL_WR) begin
			if (hv_now) begin
				st_d.ctl[flash_pe_pkg::HV_BIT] =
					CTL_WDATA[flash_pe_pkg::HV_BIT];
			end else begin
				st_d.ctl = CTL_WDATA;
				// Enable only with latch already set and loaded.
				want_hv = CTL_WDATA[flash_pe_pkg::HV_BIT];
				st_d.ctl[flash_pe_pkg::HV_BIT] = want_hv
					&& st_q.ctl[flash_pe_pkg::LATCH_BIT]
					&& CTL_WDATA[flash_pe_pkg::LATCH_BIT]
					&& st_q.loaded;
				// Clearing the latch bit forgets the load.
				if (!CTL_WDATA[flash_pe_pkg::LATCH_BIT]) begin
					st_d.loaded = 1'b0;
				end
			end
		end
		// First array write after latch set fills the latches.
		if (ARR_WR && st_q.ctl[flash_pe_pkg::LATCH_BIT]
			&& !st_q.loaded && !hv_now) begin
			st_d.loaded   = 1'b1;
			st_d.laddr    = ARR_ADDR;
			st_d.ldata    = ARR_WDATA;
			st_d.boot_hit = in_boot(ARR_ADDR);
		end
		// Stop or wait kills the high voltage at once.
		if (lpw) begin
			st_d.ctl[flash_pe_pkg::HV_BIT] = 1'b0;
			st_d.rec_cnt = 4'(flash_pe_pkg::STOP_REC_CYC);
		end else if (st_q.rec_cnt != 4'h0) begin
			st_d.rec_cnt = st_q.rec_cnt - 4'h1;
		end
		// Test bits follow writes only in special mode.
		// Special mode opens only this register; nothing else reads it.
		if (!smd) begin
			st_d.tst = flash_pe_pkg::TST_RST;
		end else if (TST_WR) begin
			st_d.tst = TST_WDATA;
		end
		// Array reads; ignored under high voltage.
		if (ARR_RD && !hv_now) begin
			st_d.rdv = 1'b1;
			st_d.rdd = CELL_RDATA;
		end
		// Voltage drives: only with enable, supply and no stop.
		st_d.hvp = hv_now && sup_ok && !lpw
			&& !st_q.ctl[flash_pe_pkg::ERASE_BIT]
			&& !(st_q.boot_hit
			&& st_q.ctl[flash_pe_pkg::BOOT_BIT]);
		st_d.hve = hv_now && sup_ok && !lpw
			&& st_q.ctl[flash_pe_pkg::ERASE_BIT];
		st_d.ebt = !st_q.ctl[flash_pe_pkg::BOOT_BIT];
	end

	// One register for the whole state record; reset clears all.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Output flip-flops, fed from the next state so they track it; CELL_ADDR is fed from the current state and ARR_ADDR, FLASH_READY also from lpw.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			CTL_RDATA   <= flash_pe_pkg::CTL_RST;
			TST_RDATA   <= flash_pe_pkg::TST_RST;
			LATCH_FULL  <= 1'b0;
			FLASH_READY <= 1'b0;
			RD_VALID    <= 1'b0;
			RD_DATA     <= '0;
			CELL_ADDR   <= '0;
			HV_PROGRAM  <= 1'b0;
			HV_ERASE    <= 1'b0;
			ERASE_BOOT  <= 1'b0;
			PGM_ADDR    <= '0;
			PGM_DATA    <= '0;
		end else begin
			CTL_RDATA   <= st_d.ctl;
			TST_RDATA   <= st_d.tst;
			LATCH_FULL  <= st_d.loaded;
			// Only the settled synchroniser stage is read, so a
			// metastable first stage never reaches this output.
			FLASH_READY <= (st_d.rec_cnt == 4'h0) && !lpw;
			RD_VALID    <= st_d.rdv;
			RD_DATA     <= st_d.rdd;
			// Latched read-back in program mode, else normal.
			CELL_ADDR   <= (st_q.ctl[flash_pe_pkg::LATCH_BIT]
				&& !st_q.ctl[flash_pe_pkg::ERASE_BIT]
				&& st_q.loaded) ? st_q.laddr : ARR_ADDR;
			HV_PROGRAM  <= st_d.hvp;
			HV_ERASE    <= st_d.hve;
			ERASE_BOOT  <= st_d.ebt;
			PGM_ADDR    <= st_d.laddr;
			PGM_DATA    <= st_d.ldata;
		end
	end

	// Enable can only rise after the latches were loaded.
	hv_needs_load_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		$rose(st_q.ctl[flash_pe_pkg::HV_BIT]) |-> $past(st_q.loaded))
		else $error("Enable set without loaded latches.");
	// Latch and erase bits stay put under enable.
	mode_frozen_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		$past(st_q.ctl[flash_pe_pkg::HV_BIT]) |->
		st_q.ctl[4:1] == $past(st_q.ctl[4:1]))
		else $error("Mode bits changed under enable.");
	// Stop drops enable in the next cycle.
	stop_abort_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		lpw |=> !st_q.ctl[flash_pe_pkg::HV_BIT] ##1 !HV_PROGRAM)
		else $error("Stop did not abort high voltage.");
	// Drive output only follows the enable bit.
	hv_gated_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(HV_PROGRAM || HV_ERASE) |-> $past(st_q.ctl[flash_pe_pkg::HV_BIT]))
		else $error("Voltage drive without enable.");
	// Drive output only with the programming supply present.
	supply_gate_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(HV_PROGRAM || HV_ERASE) |-> $past(sup_ok))
		else $error("Voltage drive without supply.");
	// Program drive only in program mode.
	prog_mode_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		HV_PROGRAM |-> !$past(st_q.ctl[flash_pe_pkg::ERASE_BIT]))
		else $error("Program drive in erase mode.");
	// Erase drive only in erase mode.
	erase_mode_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		HV_ERASE |-> $past(st_q.ctl[flash_pe_pkg::ERASE_BIT]))
		else $error("Erase drive in program mode.");
	// A guarded boot address is never programmed.
	boot_guard_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		HV_PROGRAM |-> !$past(st_q.boot_hit && st_q.ctl[3]))
		else $error("Protected boot address programmed.");
	// Boot block erase only with protection clear.
	boot_erase_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		ERASE_BOOT |-> !$past(st_q.ctl[flash_pe_pkg::BOOT_BIT]))
		else $error("Boot erase allowed under protection.");
	// Test register stays clear outside special mode.
	test_clear_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		!smd |=> st_q.tst == 8'h00)
		else $error("Test register set outside special mode.");
	// Test writes land in special mode.
	test_write_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(smd && TST_WR) |=> st_q.tst == $past(TST_WDATA))
		else $error("Test write lost in special mode.");
	// Latches do not move once loaded.
	latch_hold_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(st_q.loaded && ARR_WR) |=> $stable(st_q.laddr))
		else $error("Latched address changed.");
	// Writes with latch clear never load.
	no_load_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(!st_q.ctl[flash_pe_pkg::LATCH_BIT] && !CTL_WR) |=> !st_q.loaded)
		else $error("Latches loaded with latch clear.");
	// Reads under enable give no answer.
	read_block_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(ARR_RD && st_q.ctl[flash_pe_pkg::HV_BIT]) |=> !RD_VALID)
		else $error("Read answered under enable.");
	// Enable written together with latch from clear is refused.
	one_write_a:
	assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(CTL_WR && !st_q.ctl[flash_pe_pkg::LATCH_BIT]) |=>
		!st_q.ctl[flash_pe_pkg::HV_BIT])
		else $error("Single write started an operation.");

endmodule
